// ---- src/cct_timer_top.sv ----
/*
 four-channel 16-bit capture/compare timer with an AXI4-Lite slave.
 assumes synchronous capture pins and one 250 MHz clock.
*/
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
// Function
// - first match may lag one count clock
// - capture during compare b read still happens
// - compare registers kept after stop
// - external trigger ignored during pulse
// - match clear at ffff sets overflow
// - overflow clear before 0001 is ignored
// - counter read never captures
// - stopped timer ignores capture inputs
// - one-shot only free-run or edge-clear
// - input a as clock breaks its capture
// - both edges on input a: no capture
// - capture then interrupt next count clock
// - compare-mode register never captures
// - edge sampling twice, fxx/4 or count clock
// - one-shot active low match, inactive high
`timescale 1ns/1ns
`include "cct_defines.svh"
module cct_timer_top (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic [`CCT_AW-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [`CCT_AW-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [`CCT_NCH-1:0] capture_in_a_in,
    input wire logic [`CCT_NCH-1:0] capture_in_b_in,
    output logic [`CCT_NCH-1:0] timer_output_pin_out,
    output logic [`CCT_NCH-1:0] match_a_irq_out,
    output logic [`CCT_NCH-1:0] match_b_irq_out
);
    logic [1:0] rst_sync; // reset release chain
    logic rst_n; // synchronised reset
    cct_pkg::top_state_t st, next_st; // whole state
    logic t4, t16, t64; // prescaler ticks
    logic [`CCT_NCH-1:0] ptick; // prescaled count tick
    logic [`CCT_NCH-1:0] run; // channel running
    logic [`CCT_NCH-1:0] smp_a; // input a sample strobe
    cct_pkg::edge_evt_t [`CCT_NCH-1:0] evt_a; // filtered input a
    cct_pkg::edge_evt_t [`CCT_NCH-1:0] evt_b; // filtered input b

    // valid edge per edge-select code
    function automatic logic edge_hit(
        input logic [1:0] es, input cct_pkg::edge_evt_t e);
        case (es)
            `CCT_EDGE_FALL: edge_hit = e.fall;
            `CCT_EDGE_RISE: edge_hit = e.rise;
            `CCT_EDGE_BOTH: edge_hit = e.rise | e.fall;
            default: edge_hit = 1'h0;
        endcase
    endfunction : edge_hit

    // mapped word address check
    function automatic logic addr_ok(input logic [`CCT_AW-1:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a[4:0] <= `CCT_OFS_CNT);
    endfunction : addr_ok

    // register image of one channel word
    function automatic logic [31:0] reg_image(
        input cct_pkg::chan_t c, input logic [4:0] off);
        reg_image = 32'h0;
        case (off)
            `CCT_OFS_MODE: reg_image[3:0] = {c.ovf, c.inv_en, c.run_mode};
            `CCT_OFS_CTRL: reg_image[1:0] = {c.cap_b_en, c.cap_a_en};
            `CCT_OFS_PRESC: reg_image[5:0] = {c.es_b, c.es_a, c.clk_sel};
            // trigger bit always reads zero
            `CCT_OFS_OUTC: reg_image[3:0] = {c.sq_en, 1'h0, c.os_en, c.out_en};
            `CCT_OFS_CMPA: reg_image[15:0] = c.cmp_a;
            // a racing capture makes this value stale
            `CCT_OFS_CMPB: reg_image[15:0] = c.cmp_b;
            // plain read, no capture side effect
            `CCT_OFS_CNT: reg_image[15:0] = c.counter;
            default: reg_image = 32'h0;
        endcase
    endfunction : reg_image

    // byte-lane merge of a write
    function automatic logic [31:0] merge(
        input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merge[8*b +: 8] = wd[8*b +: 8];
            end
        end
    endfunction : merge

    // reset release through two flops
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'h1};
        end
    end
    assign rst_n = rst_sync[1];

    // shared prescaler
    cct_prescaler u_presc (
        .clock_in(clock_in),
        .rst_n_in(rst_n),
        .tick4_out(t4),
        .tick16_out(t16),
        .tick64_out(t64)
    );

    // one filter pair per channel
    for (genvar g = 0; g < `CCT_NCH; g++) begin : g_ch
        // run state gates inputs
        assign run[g] = st.ch[g].run_mode != cct_pkg::RUN_STOP;
        assign ptick[g] = (st.ch[g].clk_sel == `CCT_CLK_DIV4) ? t4 :
                          (st.ch[g].clk_sel == `CCT_CLK_DIV16) ? t16 :
                          (st.ch[g].clk_sel == `CCT_CLK_DIV64) ? t64 : 1'h0;
        // input a as count clock samples at fxx/4
        assign smp_a[g] = (st.ch[g].clk_sel == `CCT_CLK_EXT) ? t4 : ptick[g];
        cct_edge_sampler u_samp_a (
            .clock_in(clock_in),
            .rst_n_in(rst_n),
            .enable_in(run[g]),
            .sample_in(smp_a[g]),
            .pin_in(capture_in_a_in[g]),
            .evt_out(evt_a[g])
        );
        cct_edge_sampler u_samp_b (
            .clock_in(clock_in),
            .rst_n_in(rst_n),
            .enable_in(run[g]),
            .sample_in(smp_a[g]),
            .pin_in(capture_in_b_in[g]),
            .evt_out(evt_b[g])
        );
    end

    // bus slave and channel logic
    always_comb begin
        logic [3:0] trig;
        logic [4:0] off;
        logic [31:0] w;
        logic ea, eb, tick, osok, start;
        logic [15:0] lo, hi;
        cct_pkg::chan_t c;
        trig = 4'h0;
        off = 5'h0;
        w = 32'h0;
        ea = 1'h0;
        eb = 1'h0;
        tick = 1'h0;
        osok = 1'h0;
        start = 1'h0;
        lo = 16'h0;
        hi = 16'h0;
        c = '0;
        next_st = st;
        // response handshakes
        // response taken: free the address and data slots
        if (st.bus.bvalid && s_axi_bready_in) begin
            next_st.bus.bvalid = 1'h0;
            next_st.bus.aw_got = 1'h0;
            next_st.bus.w_got = 1'h0;
        end
        if (st.bus.rvalid && s_axi_rready_in) begin
            next_st.bus.rvalid = 1'h0;
        end
        // address and data taken in either order
        if (s_axi_awvalid_in && !st.bus.aw_got) begin
            next_st.bus.aw_got = 1'h1;
            next_st.bus.awaddr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !st.bus.w_got) begin
            next_st.bus.w_got = 1'h1;
            next_st.bus.wdata = s_axi_wdata_in;
            next_st.bus.wstrb = s_axi_wstrb_in;
        end
        // read: answer next cycle
        if (s_axi_arvalid_in && !st.bus.rvalid) begin
            next_st.bus.rvalid = 1'h1;
            if (addr_ok(s_axi_araddr_in)) begin
                next_st.bus.rresp = `CCT_RESP_OK;
                next_st.bus.rdata = reg_image(
                    st.ch[s_axi_araddr_in[`CCT_AW-2:`CCT_CH_LSB]],
                    s_axi_araddr_in[4:0]);
            end else begin
                next_st.bus.rresp = `CCT_RESP_ERR;
                next_st.bus.rdata = 32'h0;
            end
        end
        // write once both halves are held
        if (st.bus.aw_got && st.bus.w_got && !st.bus.bvalid) begin
            next_st.bus.bvalid = 1'h1;
            next_st.bus.bresp = addr_ok(st.bus.awaddr) ? `CCT_RESP_OK : `CCT_RESP_ERR;
            if (addr_ok(st.bus.awaddr)) begin
                c = st.ch[st.bus.awaddr[`CCT_AW-2:`CCT_CH_LSB]];
                off = st.bus.awaddr[4:0];
                w = merge(reg_image(c, off), st.bus.wdata, st.bus.wstrb);
                case (off)
                    `CCT_OFS_MODE: begin
                        c.run_mode = cct_pkg::run_mode_t'(w[1:0]);
                        c.inv_en = w[`CCT_MODE_INV];
                        // zero clears, one leaves the flag
                        c.ovf = c.ovf & w[`CCT_MODE_OVF];
                    end
                    `CCT_OFS_CTRL: begin
                        c.cap_a_en = w[`CCT_CTRL_CAPA];
                        c.cap_b_en = w[`CCT_CTRL_CAPB];
                    end
                    // edge select taken as written; stop first is software's job
                    `CCT_OFS_PRESC: begin
                        c.clk_sel = w[1:0];
                        c.es_a = w[3:2];
                        c.es_b = w[5:4];
                    end
                    `CCT_OFS_OUTC: begin
                        c.out_en = w[`CCT_OUTC_OE];
                        c.os_en = w[`CCT_OUTC_OS];
                        c.sq_en = w[`CCT_OUTC_SQ];
                        trig[st.bus.awaddr[`CCT_AW-2:`CCT_CH_LSB]] = w[`CCT_OUTC_TRIG];
                    end
                    // accepted any time; stable compares are software's duty
                    `CCT_OFS_CMPA: c.cmp_a = w[15:0];
                    `CCT_OFS_CMPB: c.cmp_b = w[15:0];
                    default: c = c;
                endcase
                next_st.ch[st.bus.awaddr[`CCT_AW-2:`CCT_CH_LSB]] = c;
            end
        end
        // channel behaviour, after software so hardware sets win
        for (int i = 0; i < `CCT_NCH; i++) begin
            c = next_st.ch[i];
            c.irq_a = 1'h0;
            c.irq_b = 1'h0;
            ea = edge_hit(st.ch[i].es_a, evt_a[i]);
            eb = edge_hit(st.ch[i].es_b, evt_b[i]);
            // counting begins at the next tick, so first match may lag
            tick = (st.ch[i].clk_sel == `CCT_CLK_EXT) ? ea : ptick[i];
            lo = (c.cmp_a < c.cmp_b) ? c.cmp_a : c.cmp_b;
            hi = (c.cmp_a < c.cmp_b) ? c.cmp_b : c.cmp_a;
            if (st.ch[i].run_mode == cct_pkg::RUN_STOP) begin
                // stopped: clear counter, drop pulse and captures
                c.counter = `CCT_CNT_RST;
                c.os_busy = 1'h0;
                c.pend_a = 1'h0;
                c.pend_b = 1'h0;
                c.ovf_hold = 1'h0;
            end else begin
                // one-shot only where the counter overflows
                osok = c.os_en && (st.ch[i].run_mode == cct_pkg::RUN_FREE ||
                       st.ch[i].run_mode == cct_pkg::RUN_EDGE_CLEAR);
                // input a retrigger during a pulse is dropped; a software trigger restarts it
                start = osok && (trig[i] || (ea && !st.ch[i].os_busy));
                // pending capture interrupts fire one count clock later
                if (tick) begin
                    c.irq_a = st.ch[i].pend_a;
                    c.irq_b = st.ch[i].pend_b;
                    c.pend_a = 1'h0;
                    c.pend_b = 1'h0;
                end
                // counter advance
                if (tick) begin
                    if (st.ch[i].run_mode == cct_pkg::RUN_MATCH_CLEAR &&
                        st.ch[i].counter == c.cmp_a) begin
                        c.counter = `CCT_CNT_RST;
                        // clearing from ffff counts as overflow
                        if (c.cmp_a == `CCT_CNT_MAX) begin
                            c.ovf = 1'h1;
                        end
                    end else begin
                        c.counter = st.ch[i].counter + 16'h0001;
                        // hold lasts until the counter reaches 0001
                        c.ovf_hold = (st.ch[i].counter == `CCT_CNT_MAX);
                    end
                    // compare matches
                    if (!c.cap_a_en && st.ch[i].counter == c.cmp_a) begin
                        c.irq_a = 1'h1;
                        if (c.sq_en) begin
                            c.pin = ~c.pin;
                        end
                    end
                    if (!c.cap_b_en && st.ch[i].counter == c.cmp_b) begin
                        c.irq_b = 1'h1;
                    end
                    // pulse active at lower match, inactive at higher
                    if (st.ch[i].os_busy && st.ch[i].counter == lo) begin
                        c.pin = 1'h1;
                    end
                    if (st.ch[i].os_busy && st.ch[i].counter == hi) begin
                        c.pin = 1'h0;
                        c.os_busy = 1'h0;
                    end
                end
                // flag set again while hold stands
                c.ovf = c.ovf | c.ovf_hold;
                // clear on input a edge mode
                if (st.ch[i].run_mode == cct_pkg::RUN_EDGE_CLEAR && ea) begin
                    c.counter = `CCT_CNT_RST;
                end
                // output inversion on valid input a edge
                if (c.inv_en && ea) begin
                    c.pin = ~c.pin;
                end
                // capture b on input a: not with both edges, not as clock
                if (c.cap_b_en && ea && st.ch[i].es_a != `CCT_EDGE_BOTH &&
                    st.ch[i].clk_sel != `CCT_CLK_EXT) begin
                    c.cmp_b = st.ch[i].counter;
                    c.pend_b = 1'h1;
                end
                // capture a on input b
                if (c.cap_a_en && eb) begin
                    c.cmp_a = st.ch[i].counter;
                    c.pend_a = 1'h1;
                end
                // trigger clears and starts the counter
                if (start) begin
                    c.counter = `CCT_CNT_RST;
                    c.os_busy = 1'h1;
                    c.pin = 1'h0;
                end
            end
            // disabled output held low
            if (!c.out_en) begin
                c.pin = 1'h0;
            end
            next_st.ch[i] = c;
        end
    end

    // register whole state
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // bus handshakes
    assign s_axi_awready_out = ~st.bus.aw_got;
    assign s_axi_wready_out = ~st.bus.w_got;
    assign s_axi_arready_out = ~st.bus.rvalid;
    assign s_axi_bvalid_out = st.bus.bvalid;
    assign s_axi_bresp_out = st.bus.bresp;
    assign s_axi_rvalid_out = st.bus.rvalid;
    assign s_axi_rdata_out = st.bus.rdata;
    assign s_axi_rresp_out = st.bus.rresp;

    // channel outputs from flops
    for (genvar o = 0; o < `CCT_NCH; o++) begin : g_out
        assign timer_output_pin_out[o] = st.ch[o].pin;
        assign match_a_irq_out[o] = st.ch[o].irq_a;
        assign match_b_irq_out[o] = st.ch[o].irq_b;
    end
endmodule : cct_timer_top

// ---- src/cct_defines.svh ----
/*
 offsets, field positions, codes and reset values of the timer block.
 assumes byte addressing on a 32-bit register bus.
*/
`ifndef CCT_DEFINES_SVH
`define CCT_DEFINES_SVH
`define CCT_NCH 4
`define CCT_AW 8
// per-channel window and register offsets
`define CCT_CH_LSB 5
`define CCT_OFS_MODE 5'h00
`define CCT_OFS_CTRL 5'h04
`define CCT_OFS_PRESC 5'h08
`define CCT_OFS_OUTC 5'h0c
`define CCT_OFS_CMPA 5'h10
`define CCT_OFS_CMPB 5'h14
`define CCT_OFS_CNT 5'h18
// mode word bits
`define CCT_MODE_INV 2
`define CCT_MODE_OVF 3
// capture control bits
`define CCT_CTRL_CAPA 0
`define CCT_CTRL_CAPB 1
// output control bits
`define CCT_OUTC_OE 0
`define CCT_OUTC_OS 1
`define CCT_OUTC_TRIG 2
`define CCT_OUTC_SQ 3
// count clock and edge codes
`define CCT_CLK_DIV4 2'h0
`define CCT_CLK_DIV16 2'h1
`define CCT_CLK_DIV64 2'h2
`define CCT_CLK_EXT 2'h3
`define CCT_EDGE_FALL 2'h0
`define CCT_EDGE_RISE 2'h1
`define CCT_EDGE_BOTH 2'h3
// counter values and bus response codes
`define CCT_CNT_RST 16'h0000
`define CCT_CNT_MAX 16'hffff
`define CCT_RESP_OK 2'h0
`define CCT_RESP_ERR 2'h2
`endif

// ---- src/cct_pkg.sv ----
/*
 types shared by the timer block files.
 assumes the defines header is on the include path.
*/
`include "cct_defines.svh"
package cct_pkg;
    // run modes, stop first
    typedef enum logic [1:0] {
        RUN_STOP, RUN_EDGE_CLEAR, RUN_FREE, RUN_MATCH_CLEAR
    } run_mode_t;
    // filtered edge pulses
    typedef struct packed {logic rise; logic fall;} edge_evt_t;
    // edge filter state
    typedef struct packed {
        logic [1:0] smp;
        logic level;
        edge_evt_t evt;
    } edge_state_t;
    // prescaler state
    typedef struct packed {
        logic [5:0] div;
        logic t4; logic t16; logic t64;
    } presc_state_t;
    // one timer channel
    typedef struct packed {
        run_mode_t run_mode;
        logic inv_en; logic ovf; logic ovf_hold;
        logic cap_a_en; logic cap_b_en;
        logic [1:0] clk_sel; logic [1:0] es_a; logic [1:0] es_b;
        logic out_en; logic os_en; logic sq_en;
        logic [15:0] counter;
        logic [15:0] cmp_a; logic [15:0] cmp_b;
        logic pin; logic os_busy;
        logic pend_a; logic pend_b;
        logic irq_a; logic irq_b;
    } chan_t;
    // register bus slave state
    typedef struct packed {
        logic aw_got; logic [`CCT_AW-1:0] awaddr;
        logic w_got; logic [31:0] wdata; logic [3:0] wstrb;
        logic bvalid; logic [1:0] bresp;
        logic rvalid; logic [1:0] rresp; logic [31:0] rdata;
    } bus_t;
    typedef struct packed {bus_t bus; chan_t [`CCT_NCH-1:0] ch;} top_state_t;
endpackage : cct_pkg

// ---- src/cct_prescaler.sv ----
/*
 free divider giving one-cycle ticks at main clock /4, /16 and /64.
 assumes a synchronised active-low reset.
*/
`timescale 1ns/1ns
module cct_prescaler (
    input wire logic clock_in,
    input wire logic rst_n_in,
    output logic tick4_out,
    output logic tick16_out,
    output logic tick64_out
);
    cct_pkg::presc_state_t st, next_st; // divider state

    // count and flag terminal counts
    always_comb begin
        next_st = st;
        next_st.div = st.div + 6'h01;
        next_st.t4 = &st.div[1:0];
        next_st.t16 = &st.div[3:0];
        next_st.t64 = &st.div;
    end

    // register state
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick4_out = st.t4;
    assign tick16_out = st.t16;
    assign tick64_out = st.t64;
endmodule : cct_prescaler

// ---- src/cct_edge_sampler.sv ----
/*
 edge filter: a level counts only after two equal samples.
 assumes a synchronous pin and a sample strobe from the owner.
*/
`timescale 1ns/1ns
module cct_edge_sampler (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic sample_in,
    input wire logic pin_in,
    output cct_pkg::edge_evt_t evt_out
);
    cct_pkg::edge_state_t st, next_st; // filter state

    // sample, filter, detect
    always_comb begin
        next_st = st;
        next_st.evt = '0;
        if (!enable_in) begin
            // idle: track pin so start gives no false edge
            next_st.smp = {pin_in, pin_in};
            next_st.level = pin_in;
        end else if (sample_in) begin
            next_st.smp = {st.smp[0], pin_in};
            // two equal samples differing from held level
            if (st.smp[0] == pin_in && pin_in != st.level) begin
                next_st.level = pin_in;
                next_st.evt.rise = pin_in;
                next_st.evt.fall = ~pin_in;
            end
        end
    end

    // register state
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign evt_out = st.evt;
endmodule : cct_edge_sampler

// ---- dv/cct_timer_assertions.sv ----
/*
 bus handshake and interrupt timing checks for the timer top.
 assumes it is bound to the top and sees only its ports.
*/
`timescale 1ns/1ns
`include "cct_defines.svh"
module cct_timer_assertions (
    input wire logic clock_in, rstn_in, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in,
    s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out,
    s_axi_rvalid_out, s_axi_rready_in,
    input wire logic [1:0] s_axi_bresp_out, s_axi_rresp_out,
    input wire logic [`CCT_AW-1:0] s_axi_araddr_in,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [`CCT_NCH-1:0] match_a_irq_out, match_b_irq_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    // both halves taken together, answer within two cycles
    a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out) else $error("write unanswered");
    a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out
        && $stable(s_axi_bresp_out)) else $error("write response dropped");
    a_w_blocked: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write taken while answering");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read unanswered");
    a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
        && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out)) else $error("read data moved");
    a_ar_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("address taken while answering");
    // hole in the window or misaligned address: error, data zero
    a_bad_read: assert property (s_axi_arvalid_in && s_axi_arready_out && (s_axi_araddr_in[4:0]
        > 5'h18 || s_axi_araddr_in[1:0] != 2'h0) |=> s_axi_rresp_out == `CCT_RESP_ERR
        && s_axi_rdata_out == 32'h0) else $error("bad read not refused");
    // interrupts only on count ticks, so channel 0 pulses at least four cycles apart
    a_irq_a_gap: assert property (match_a_irq_out[0] |=> !match_a_irq_out[0] [*3])
        else $error("match a pulse too close");
    a_irq_b_gap: assert property (match_b_irq_out[0] |=> !match_b_irq_out[0] [*3])
        else $error("match b pulse too close");
endmodule : cct_timer_assertions
bind cct_timer_top cct_timer_assertions u_cct_timer_assertions (.*);

// ---- dv/cct_pin_src.sv ----
/*
 external trigger source: a fire request gives a held pulse on both pins.
 assumes fire requests are one-cycle pulses from the bench.
*/
`timescale 1ns/1ns
module cct_pin_src (
    input wire logic clock_in,
    input wire logic [3:0] fire_in,
    output logic [3:0] pin_a_out,
    output logic [3:0] pin_b_out
);
    logic [5:0] left [4] = '{default: 6'h00}; // cycles of pulse still to hold
    // hold 40 cycles, ten /4 ticks, well over two count clocks
    always @(posedge clock_in) begin
        for (int i = 0; i < 4; i++) begin
            if (fire_in[i]) left[i] <= 6'h28;
            else if (left[i] != 6'h00) left[i] <= left[i] - 6'h01;
        end
    end
    // pins idle low between pulses, both pins alike
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_a_out[i] = left[i] != 6'h00;
        end
    end
    assign pin_b_out = pin_a_out;
endmodule : cct_pin_src

// ---- dv/cct_timer_top_tb.sv ----
/*
 self-checking bench for the timer top: bus, capture and one-shot cases.
 assumes the design and checker files are compiled first.
*/
`timescale 1ns/1ns
`include "cct_defines.svh"
module cct_timer_top_tb;
    logic clock_in = 0, rstn_in = 0, s_axi_awvalid_in = 0, s_axi_wvalid_in = 0;
    logic s_axi_bready_in = 0, s_axi_arvalid_in = 0, s_axi_rready_in = 0;
    logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
    logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, rd;
    logic [3:0] s_axi_wstrb_in = 4'hf, fire = 0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rr;
    logic [3:0] capture_in_a_in, capture_in_b_in, timer_output_pin_out;
    logic [3:0] match_a_irq_out, match_b_irq_out;
    int err_total = 0, n_compared = 0, nb = 0;
    always #2 clock_in = ~clock_in;
    cct_timer_top u_cct_timer_top (.*);
    cct_pin_src u_cct_pin_src (.clock_in, .fire_in(fire), .pin_a_out(capture_in_a_in),
        .pin_b_out(capture_in_b_in));
    // count match b interrupts of every channel
    always @(posedge clock_in) nb <= nb + $countones(match_b_irq_out);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [7:0] ad(input int c, input logic [4:0] o);
        return {1'b0, c[1:0], o};
    endfunction : ad
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
        @(posedge clock_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1;
        s_axi_wvalid_in <= 1;
        s_axi_bready_in <= 1;
        do begin
            @(posedge clock_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 0;
        end while (!s_axi_bvalid_out);
        s_axi_bready_in <= 0;
        chk(s_axi_bresp_out, e);
    endtask : wr
    task automatic rdw(input logic [7:0] a);
        @(posedge clock_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1;
        s_axi_rready_in <= 1;
        do begin
            @(posedge clock_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 0;
        end while (!s_axi_rvalid_out);
        s_axi_rready_in <= 0;
        rd = s_axi_rdata_out;
        rr = s_axi_rresp_out;
    endtask : rdw
    // one external pulse, then time for the filter to settle
    task automatic hit(input int c);
        @(posedge clock_in);
        fire[c] <= 1;
        @(posedge clock_in);
        fire[c] <= 0;
        repeat (80) @(posedge clock_in);
    endtask : hit
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    initial begin
        #100000;
        err_total++;
        complete_run;
    end
    initial begin
        int c, a, b, k, j, w, n0;
        void'($urandom(32'h7fa4ebac));
        repeat (3) @(posedge clock_in);
        rstn_in <= 1;
        repeat (3) @(posedge clock_in);
        for (c = 0; c < 4; c++) begin
            rdw(ad(c, `CCT_OFS_MODE));
            chk(rd, 0);
            rdw(ad(c, `CCT_OFS_CNT));
            chk(rd, 0);
        end
        rdw(8'h1c);
        chk({rr, rd[29:0]}, {`CCT_RESP_ERR, 30'h0});
        wr(8'h3c, 32'h1, `CCT_RESP_ERR);
        c = $urandom % 4;
        wr(ad(c, `CCT_OFS_CMPB), 32'hffff);
        wr(ad(c, `CCT_OFS_PRESC), 32'h4);
        wr(ad(c, `CCT_OFS_CTRL), 32'h2);
        hit(c);
        rdw(ad(c, `CCT_OFS_CMPB));
        chk(rd, 32'hffff);
        wr(ad(c, `CCT_OFS_CTRL), 32'h0);
        wr(ad(c, `CCT_OFS_MODE), 32'h2);
        hit(c);
        rdw(ad(c, `CCT_OFS_CNT));
        rdw(ad(c, `CCT_OFS_CMPB));
        chk(rd, 32'hffff);
        wr(ad(c, `CCT_OFS_MODE), 32'h0);
        wr(ad(c, `CCT_OFS_PRESC), 32'hc);
        wr(ad(c, `CCT_OFS_CTRL), 32'h2);
        wr(ad(c, `CCT_OFS_MODE), 32'h2);
        hit(c);
        rdw(ad(c, `CCT_OFS_CMPB));
        chk(rd, 32'hffff);
        wr(ad(c, `CCT_OFS_MODE), 32'h0);
        wr(ad(c, `CCT_OFS_PRESC), 32'h4);
        wr(ad(c, `CCT_OFS_MODE), 32'h2);
        n0 = nb;
        hit(c);
        chk(nb - n0, 1);
        rdw(ad(c, `CCT_OFS_CMPB));
        chk(rd < 32'hffff, 1);
        // one-shot with compare a first above compare b, then below
        for (k = 0; k < 2; k++) begin
            a = 4 + $urandom % 12;
            b = a + 1 + $urandom % 8;
            wr(ad(c, `CCT_OFS_MODE), 32'h0);
            wr(ad(c, `CCT_OFS_CTRL), 32'h0);
            wr(ad(c, `CCT_OFS_PRESC), 32'h0);
            wr(ad(c, `CCT_OFS_CMPA), k ? a : b);
            wr(ad(c, `CCT_OFS_CMPB), k ? b : a);
            wr(ad(c, `CCT_OFS_MODE), 32'h2);
            wr(ad(c, `CCT_OFS_OUTC), 32'h7);
            w = 0;
            for (j = 0; j < 2000 && timer_output_pin_out[c] !== 1'b1; j++) @(posedge clock_in);
            while (timer_output_pin_out[c] === 1'b1 && w < 2000) begin
                @(posedge clock_in);
                w++;
            end
            chk(w, (b - a) * 4);
        end
        complete_run;
    end
endmodule : cct_timer_top_tb
